// File: hw/dfpr_regs.v
`include "dfpr_defines.vh"

module dfpr_regs #(
  parameter [`DFPR_RANGE_W-1:0] RANGE_DEFAULT = `DFPR_RANGE_RST
)(
  // Clock and reset
  input  wire                            clk,
  input  wire                            arst_n,
  // Register port from the serial slave
  input  wire                            wr_en,
  input  wire                            rd_en,
  input  wire [`DFPR_ADDR_W-1:0]         addr,
  input  wire [`DFPR_DATA_W-1:0]         wr_data,
  output reg  [`DFPR_DATA_W-1:0]         rd_data,
  // Output enable configuration and pin
  input  wire                            oe_sw_mode,
  input  wire                            oe_pin,
  // To the fractional divider
  output reg  signed [`DFPR_WORD_W-1:0]  freq_offset_word,
  output reg                             freq_update,
  output reg  [`DFPR_RANGE_W-1:0]        pull_range_code,
  output reg  [`DFPR_CPPM_W-1:0]         pull_half_range_cppm,
  output reg  signed [`DFPR_PROD_W-1:0]  freq_shift_product,
  output reg                             out_enable
);

  reg  [`DFPR_LOW_W-1:0]     freq_offset_low_half_reg;
  reg  [`DFPR_HIGH_MSB:0]    freq_offset_high_half_reg;
  reg                        oe_sw_reg;
  wire [`DFPR_SYNC_N-1:0]    async_in;
  wire [`DFPR_SYNC_N-1:0]    sync_out;
  reg  [`DFPR_CPPM_W-1:0]    cppm_next;
  reg  [`DFPR_DATA_W-1:0]    rd_next;
  wire                       wr_low;
  wire                       wr_high;
  wire                       wr_range;
  wire                       sw_mode;
  wire                       pin_level;

  assign wr_low   = wr_en && (addr == `DFPR_OFF_LOW);
  assign wr_high  = wr_en && (addr == `DFPR_OFF_HIGH);
  assign wr_range = wr_en && (addr == `DFPR_OFF_RANGE);
  assign async_in  = {oe_sw_mode, oe_pin};
  assign sw_mode   = sync_out[`DFPR_SYNC_MODE];
  assign pin_level = sync_out[`DFPR_SYNC_PIN];

  // Pin and strap cross in from outside; only the second stage is read
  genvar sync_idx;
  generate
    for (sync_idx = 0; sync_idx < `DFPR_SYNC_N; sync_idx = sync_idx + 1)
    begin : g_sync
      reg [1:0] sync_pair_reg;
      always @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          sync_pair_reg <= `DFPR_SYNC_RST;
        end
        else
        begin
          sync_pair_reg <= {sync_pair_reg[0], async_in[sync_idx]};
        end
      end
      // First stage may be metastable, so logic sees only the second
      assign sync_out[sync_idx] = sync_pair_reg[1];
    end
  endgenerate

  // Low half is only staged; the divider never sees it on its own
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      freq_offset_low_half_reg <= `DFPR_LOW_RST;
    end
    else if (wr_low)
    begin
      freq_offset_low_half_reg <= wr_data;
    end
  end

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      freq_offset_high_half_reg <= `DFPR_HIGH_RST;
    end
    else if (wr_high)
    begin
      // Bits above the word are dropped here; only bit 10 reads back, through oe_sw_reg
      freq_offset_high_half_reg <= wr_data[`DFPR_HIGH_MSB:0];
    end
  end

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      oe_sw_reg <= `DFPR_OE_RST;
    end
    else if (wr_high && sw_mode)
    begin
      // In pin mode the stored bit is frozen, not cleared
      oe_sw_reg <= wr_data[`DFPR_OE_BIT];
    end
  end

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pull_range_code <= RANGE_DEFAULT;
    end
    else if (wr_range)
    begin
      pull_range_code <= wr_data[`DFPR_RANGE_MSB:0];
    end
  end

  // Commit on high-half write only; a lone low write never reaches the divider
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      freq_offset_word <= {`DFPR_WORD_W{1'b0}};
    end
    else if (wr_high)
    begin
      freq_offset_word <= {wr_data[`DFPR_HIGH_MSB:0], freq_offset_low_half_reg};
    end
  end

  // One-cycle strobe aligned with the new word
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      freq_update <= 1'b0;
    end
    else
    begin
      freq_update <= wr_high;
    end
  end

  // Output enable selection
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      out_enable <= 1'b0;
    end
    else
    begin
      out_enable <= sw_mode ? oe_sw_reg : pin_level;
    end
  end

  // Half range lookup, hundredths of a ppm
  always @*
  begin
    case (pull_range_code)
      4'h0:    cppm_next = 19'h00271;
      4'h1:    cppm_next = 19'h003e8;
      4'h2:    cppm_next = 19'h004e2;
      4'h3:    cppm_next = 19'h009c4;
      4'h4:    cppm_next = 19'h01388;
      4'h5:    cppm_next = 19'h01f40;
      4'h6:    cppm_next = 19'h02710;
      4'h7:    cppm_next = 19'h030d4;
      4'h8:    cppm_next = 19'h03a98;
      4'h9:    cppm_next = 19'h04e20;
      4'ha:    cppm_next = 19'h09c40;
      4'hb:    cppm_next = 19'h0ea60;
      4'hc:    cppm_next = 19'h13880;
      4'hd:    cppm_next = 19'h1d4c0;
      4'he:    cppm_next = 19'h27100;
      default: cppm_next = 19'h4e200;
    endcase
  end

  // Signed product; dividing by the full-scale word gives the shift in hundredths
  // of a ppm. Division is left downstream to keep this path short.
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pull_half_range_cppm <= {`DFPR_CPPM_W{1'b0}};
    end
    else
    begin
      pull_half_range_cppm <= cppm_next;
    end
  end

  // Product lags the range by two cycles after a range change
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      freq_shift_product <= {`DFPR_PROD_W{1'b0}};
    end
    else
    begin
      freq_shift_product <= freq_offset_word * $signed({1'b0, pull_half_range_cppm});
    end
  end

  // Read mux; unused bits and unmapped offsets read zero
  always @*
  begin
    rd_next = `DFPR_RD_RST;
    case (addr)
      `DFPR_OFF_LOW:   rd_next = freq_offset_low_half_reg;
      `DFPR_OFF_HIGH:  rd_next = {`DFPR_HIGH_PAD, oe_sw_reg, freq_offset_high_half_reg};
      `DFPR_OFF_RANGE: rd_next = {`DFPR_RANGE_PAD, pull_range_code};
      default:         rd_next = `DFPR_RD_RST;
    endcase
  end

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rd_data <= `DFPR_RD_RST;
    else if (rd_en)
      rd_data <= rd_next;
  end

endmodule // dfpr_regs

// File: hw/dfpr_defines.vh
`ifndef DFPR_DEFINES_VH
`define DFPR_DEFINES_VH
// Contract
// - Low register bits 15:0 hold offset word bits 15:0, read and write.
// - High register bits 9:0 hold offset word bits 25:16, read and write.
// - Power-up clears all 26 offset word bits: nominal frequency.
// - Offset word is a signed two's-complement value.
// - Frequency changes only on a high-half write, using both halves then.
// - High register bit 10 is software output enable, reset 0, 1 enables.
// - Software enable applies only in software mode; else writes ignored.
// - High register bits 15:11 read zero and ignore writes.
// - Word 33554431 is full positive half range; values scale linearly.

// Register offsets
`define DFPR_ADDR_W         8
`define DFPR_OFF_LOW        8'h00
`define DFPR_OFF_HIGH       8'h01
`define DFPR_OFF_RANGE      8'h02

// Field layout
`define DFPR_DATA_W         16
`define DFPR_WORD_W         26
`define DFPR_LOW_W          16
`define DFPR_HIGH_MSB       9
`define DFPR_OE_BIT         10
`define DFPR_RANGE_W        4
`define DFPR_RANGE_MSB      3

// Reset values
`define DFPR_LOW_RST        16'h0000
`define DFPR_HIGH_RST       10'h000
`define DFPR_OE_RST         1'b0
`define DFPR_RANGE_RST      4'h9
`define DFPR_RD_RST         16'h0000

// Scaling: half range in hundredths of a ppm, full-scale word
`define DFPR_CPPM_W         19
`define DFPR_PROD_W         45
`define DFPR_FULL_SCALE     26'h1ffffff

// Synchroniser layout: bit 1 mode strap, bit 0 enable pin
`define DFPR_SYNC_N         2
`define DFPR_SYNC_MODE      1
`define DFPR_SYNC_PIN       0
`define DFPR_SYNC_RST       2'b00

// Read-back zero padding
`define DFPR_HIGH_PAD       5'h00
`define DFPR_RANGE_PAD      12'h000
`endif

// File: tb/dfpr_host.sv
module dfpr_host (
  input  logic        clk,
  output logic        wr_en, rd_en,
  output logic [7:0]  addr,
  output logic [15:0] wr_data
);
  timeunit 1ns;
  timeprecision 1ns;
  int gap = 0;
  always @(posedge clk) gap <= gap + 1;
  initial {wr_en, rd_en, addr, wr_data} = '0;
  // Released data inverted so a stale value never looks valid
  task automatic acc(logic w, logic [7:0] a, logic [15:0] d);
    @(posedge clk);
    #1 {wr_en, rd_en, addr, wr_data} = {w, !w, a, d};
    @(posedge clk);
    #1 {wr_en, rd_en, wr_data} = {2'b00, ~d};
  endtask
  // Called only once reset is released
  task automatic set(logic [15:0] lo, logic [15:0] hi);
    acc(1, 8'h00, lo);
    while (gap < 2632) @(posedge clk);
    acc(1, 8'h01, hi);
    gap = 0;
  endtask
endmodule // dfpr_host

// File: tb/dfpr_regs_sva.sv
module dfpr_regs_sva (
  input logic clk, arst_n, wr_en, rd_en, oe_sw_mode, oe_pin, freq_update, out_enable,
  input logic [7:0] addr,
  input logic [15:0] wr_data, rd_data,
  input logic signed [25:0] freq_offset_word,
  input logic [18:0] pull_half_range_cppm,
  input logic signed [44:0] freq_shift_product
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence hi_wr; wr_en && addr == 8'h01; endsequence
  sequence lo_rd; wr_en && addr == 8'h00 ##2 rd_en && addr == 8'h00; endsequence
  hi_set_a: assert property (hi_wr |=> freq_update && freq_offset_word[25:16] == $past(wr_data[9:0]))
    else $error("high half lost");
  word_hold_a: assert property (!freq_update |-> $stable(freq_offset_word))
    else $error("word moved");
  lo_back_a: assert property (lo_rd |=> rd_data == $past(wr_data, 3))
    else $error("low readback");
  rsv_zero_a: assert property (rd_en && addr == 8'h01 |=> rd_data[15:11] == 5'h00)
    else $error("reserved set");
  oe_hw_a: assert property ((!oe_sw_mode)[*4] ##0 $past(arst_n, 3) |-> out_enable == $past(oe_pin, 3))
    else $error("pin ignored");
  oe_sw_a: assert property (oe_sw_mode[*4] ##0 hi_wr |=> ##1 out_enable == $past(wr_data[10], 2))
    else $error("enable bit ignored");
  rst_word_a: assert property ($rose(arst_n) |-> freq_offset_word == 26'h0 && !freq_update)
    else $error("word not cleared");
  prod_a: assert property (freq_update |=> freq_shift_product ==
    $past(freq_offset_word) * $signed({1'b0, $past(pull_half_range_cppm)})) else $error("bad scaling");
endmodule // dfpr_regs_sva
bind dfpr_regs dfpr_regs_sva dfpr_regs_sva_inst (.*);

// File: tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, arst_n = 0, oe_sw_mode = 1, oe_pin = 0, wr_en, rd_en, freq_update, out_enable;
  logic [7:0] addr;
  logic [15:0] wr_data, rd_data;
  logic signed [25:0] freq_offset_word;
  logic [3:0] pull_range_code;
  logic [18:0] pull_half_range_cppm;
  logic signed [44:0] freq_shift_product;
  logic [25:0] w;
  int err_total = 0, total_checks = 0, seed = 24291;
  always #5 clk = ~clk;
  dfpr_regs dfpr_regs_inst (.*);
  dfpr_host dfpr_host_inst (.*);
  function automatic logic [15:0] hi_img(logic [25:0] v);
    return {5'h00, v[3], v[25:16]};
  endfunction
  task automatic chk(string n, logic [25:0] e, logic [25:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic rd(logic [7:0] a);
    dfpr_host_inst.acc(0, a, 16'h0000);
  endtask
  task automatic stop_test;
    if (err_total == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #400000 err_total++;
    stop_test;
  end
  initial
  begin
    repeat (5) @(posedge clk);
    #1 arst_n = 1;
    rd(8'h01);
    chk("high_rst", 16'h0000, rd_data);
    rd(8'h02);
    chk("range_rst", 16'h0009, rd_data);
    chk("cppm_rst", 19'd20000, pull_half_range_cppm);
    rd(8'h03);
    chk("unmapped", 16'h0000, rd_data);
    for (int i = 0; i < 6; i++)
    begin
      w = i == 0 ? 26'h1ffffff : i == 1 ? 26'h2000000 : i == 5 ? 26'h0e66666 : 26'($random(seed));
      dfpr_host_inst.set(w[15:0], hi_img(w));
      chk("word", w, freq_offset_word);
      rd(8'h01);
      chk("high", hi_img(w), rd_data);
      chk("oe", w[3], out_enable);
      dfpr_host_inst.acc(1, 8'h00, ~w[15:0]);
      rd(8'h00);
      chk("low", {~w[15:0]}, rd_data);
      chk("staged", w, freq_offset_word);
    end
    // Stored enable bit is 0 here, so only the pin can raise the output
    oe_sw_mode = 0;
    oe_pin = 1;
    dfpr_host_inst.set(16'h0000, 16'hffff);
    rd(8'h01);
    chk("high_hw", 16'h03ff, rd_data);
    chk("oe_pin", 1, out_enable);
    dfpr_host_inst.acc(1, 8'h02, 16'hffff);
    rd(8'h02);
    chk("range", 16'h000f, rd_data);
    chk("code", 4'hf, pull_range_code);
    chk("cppm", 19'd320000, pull_half_range_cppm);
    stop_test;
  end
endmodule // tb
